// *** core/oma_consts.svh ***
// constants for the operating-mode and address-map block
`ifndef OMA_CONSTS_SVH
`define OMA_CONSTS_SVH
`define OMA_ADDR_W 24
`define OMA_REG_ADDR_W 4
// register offsets on the plain register port
`define OMA_OFF_FLASH_SEL 4'h0
`define OMA_OFF_SYS_CTRL 4'h1
`define OMA_OFF_BUS_CTRL 4'h2
`define OMA_OFF_AREA_WIDTH 4'h3
`define OMA_OFF_MODE_STAT 4'h4
`define OMA_OFF_PORT_FUNC 4'h5
`define OMA_OFF_PORTC_DIR 4'h6
// field positions
`define OMA_BIT_WINDOW_EN 3
`define OMA_BIT_RAM_EN 0
`define OMA_BIT_EXT_AREA_EN 5
`define OMA_BIT_LWR_OFF 2
`define OMA_AREA_MSB 23
`define OMA_AREA_LSB 21
// reset values
`define OMA_RST_FLASH_SEL 8'h00
`define OMA_RST_SYS_CTRL 8'h01
`define OMA_RST_BUS_CTRL 8'h00
`define OMA_RST_AREA_WIDTH_16 8'hFF
`define OMA_RST_AREA_WIDTH_8 8'h00
`define OMA_RST_PORT_FUNC 8'h00
`define OMA_RST_PORTC_DIR 8'h00
`define OMA_RST_MODE_CODE 4'h0
`define OMA_RST_RDATA 8'h00
`define OMA_RST_AREA 3'h0
// width register value with every area narrow
`define OMA_AREA_ALL_NARROW 8'h00
// write masks
`define OMA_MASK_FLASH_SEL 8'h08
`define OMA_MASK_SYS_CTRL 8'hBF
// address map boundaries
`define OMA_A_ROM_LOW_END 24'h010000
`define OMA_A_ROM_END 24'h060000
`define OMA_A_RSV1_END 24'h080000
`define OMA_A_RSV2_LO 24'hFF7400
`define OMA_A_RAM_LO 24'hFF7C00
`define OMA_A_RAM_END 24'hFFFC00
`define OMA_A_IO1_LO 24'hFFFE50
`define OMA_A_IO1_END 24'hFFFF08
`define OMA_A_IO2_LO 24'hFFFF28
`define OMA_A_FLASH_LO 24'hFFFFC8
`define OMA_A_FLASH_HI 24'hFFFFCB
// mode codes on flash write enable plus the three mode inputs
`define OMA_MODE_4 4'h4
`define OMA_MODE_5 4'h5
`define OMA_MODE_6 4'h6
`define OMA_MODE_7 4'h7
`define OMA_MODE_10 4'hA
`define OMA_MODE_11 4'hB
`define OMA_MODE_14 4'hE
`define OMA_MODE_15 4'hF
`endif

// *** core/oma_mode_map.sv ***
// operating-mode control, pin function and address-map decoder
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "oma_consts.svh"

module oma_mode_map (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [2:0] i_mode_select_inputs,
   input wire logic i_flash_write_enable_pin,
   input wire logic [`OMA_REG_ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [`OMA_ADDR_W-1:0] i_cpu_addr,
   output logic [7:0] o_reg_rdata,
   output oma_pkg::oma_decode_type o_decode,
   output oma_pkg::oma_pins_type o_pins,
   output logic o_bus_16bit,
   output logic o_rom_enable,
   output logic o_flash_prog_allowed,
   output logic o_mode_bad
);

   ////////////////////////////////////////////////////////////////////////////
   // mode capture and classification

   logic [3:0] mode_code;
   logic captured;
   oma_pkg::oma_class_type mode_class;
   oma_pkg::oma_class_type next_mode_class;
   logic flash_mode;
   logic next_flash_mode;
   logic [7:0] flash_select_control_reg;
   logic [7:0] system_control_reg;
   logic [7:0] bus_control_low_reg;
   logic [7:0] area_width;
   logic [7:0] pin_function_ctrl_one;
   logic [7:0] portc_dir;
   logic flash_reg_window_enable;
   logic internal_ram_enable;
   logic external_area_enable;
   logic expanded;

   // code of the strapped mode, taken after reset release
   always_comb begin
      next_mode_class = oma_pkg::OMA_CLS_BAD;
      next_flash_mode = 1'b0;
      unique case ({i_flash_write_enable_pin, i_mode_select_inputs})
         `OMA_MODE_4, `OMA_MODE_5: next_mode_class = oma_pkg::OMA_CLS_EXP_NOROM;
         `OMA_MODE_6: next_mode_class = oma_pkg::OMA_CLS_EXP_ROM;
         `OMA_MODE_7: next_mode_class = oma_pkg::OMA_CLS_SINGLE;
         `OMA_MODE_10, `OMA_MODE_14: begin
            next_mode_class = oma_pkg::OMA_CLS_EXP_ROM;
            next_flash_mode = 1'b1;
         end
         `OMA_MODE_11, `OMA_MODE_15: begin
            next_mode_class = oma_pkg::OMA_CLS_SINGLE;
            next_flash_mode = 1'b1;
         end
         default: next_mode_class = oma_pkg::OMA_CLS_BAD;
      endcase
   end

   // latch the mode once after reset; inputs are assumed steady afterwards
   // the strap is read once, so a later change on the pins cannot move the map
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         captured <= 1'b0;
         mode_code <= `OMA_RST_MODE_CODE;
         mode_class <= oma_pkg::OMA_CLS_BAD;
         flash_mode <= 1'b0;
      end else if (!captured) begin
         captured <= 1'b1;
         mode_code <= {i_flash_write_enable_pin, i_mode_select_inputs};
         mode_class <= next_mode_class;
         flash_mode <= next_flash_mode;
      end
   end

   // control bits picked out of their registers
   assign expanded = (mode_class == oma_pkg::OMA_CLS_EXP_NOROM) ||
                     (mode_class == oma_pkg::OMA_CLS_EXP_ROM);
   assign flash_reg_window_enable = flash_select_control_reg[`OMA_BIT_WINDOW_EN];
   assign internal_ram_enable = system_control_reg[`OMA_BIT_RAM_EN];
   assign external_area_enable = bus_control_low_reg[`OMA_BIT_EXT_AREA_EN];

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   // flash select register: only the window enable bit is stored
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         flash_select_control_reg <= `OMA_RST_FLASH_SEL;
      end else if (i_reg_wr && i_reg_addr == `OMA_OFF_FLASH_SEL) begin
         flash_select_control_reg <= i_reg_wdata & `OMA_MASK_FLASH_SEL;
      end
   end

   // system control register carrying the ram enable
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         system_control_reg <= `OMA_RST_SYS_CTRL;
      end else if (i_reg_wr && i_reg_addr == `OMA_OFF_SYS_CTRL) begin
         system_control_reg <= i_reg_wdata & `OMA_MASK_SYS_CTRL;
      end
   end

   // bus control low register carrying the external area enable
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         bus_control_low_reg <= `OMA_RST_BUS_CTRL;
      end else if (i_reg_wr && i_reg_addr == `OMA_OFF_BUS_CTRL) begin
         bus_control_low_reg <= i_reg_wdata;
      end
   end

   // per-area access width, one bit per area, 1 means 16-bit
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         area_width <= `OMA_RST_AREA_WIDTH_8;
      end else if (!captured) begin
         area_width <= (next_mode_class == oma_pkg::OMA_CLS_EXP_NOROM &&
                        !i_mode_select_inputs[0]) ?
                       `OMA_RST_AREA_WIDTH_16 : `OMA_RST_AREA_WIDTH_8;
      end else if (i_reg_wr && i_reg_addr == `OMA_OFF_AREA_WIDTH) begin
         area_width <= i_reg_wdata;
      end
   end

   // pin function control: address enables of ports a and b in rom-enabled expanded modes
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pin_function_ctrl_one <= `OMA_RST_PORT_FUNC;
      end else if (i_reg_wr && i_reg_addr == `OMA_OFF_PORT_FUNC) begin
         pin_function_ctrl_one <= i_reg_wdata;
      end
   end

   // port c direction: in rom-enabled expanded modes a set bit turns that pin into an address output
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         portc_dir <= `OMA_RST_PORTC_DIR;
      end else if (i_reg_wr && i_reg_addr == `OMA_OFF_PORTC_DIR) begin
         portc_dir <= i_reg_wdata;
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_reg_rdata <= `OMA_RST_RDATA;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `OMA_OFF_FLASH_SEL: o_reg_rdata <= flash_select_control_reg;
            `OMA_OFF_SYS_CTRL: o_reg_rdata <= system_control_reg;
            `OMA_OFF_BUS_CTRL: o_reg_rdata <= bus_control_low_reg;
            `OMA_OFF_AREA_WIDTH: o_reg_rdata <= area_width;
            `OMA_OFF_MODE_STAT: o_reg_rdata <= {4'h0, mode_code};
            `OMA_OFF_PORT_FUNC: o_reg_rdata <= pin_function_ctrl_one;
            `OMA_OFF_PORTC_DIR: o_reg_rdata <= portc_dir;
            default: o_reg_rdata <= `OMA_RST_RDATA;
         endcase
      end else begin
         o_reg_rdata <= `OMA_RST_RDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode outputs and pin functions

   // pin use worked out combinationally, then registered below
   oma_pkg::oma_pins_type next_pins;

   // pin use per mode
   always_comb begin
      next_pins = '0;
      unique case (mode_class)
         oma_pkg::OMA_CLS_EXP_NOROM: begin
            next_pins.port_a_addr = 8'hFF;
            next_pins.port_b_addr = 8'hFF;
            next_pins.port_c_addr = 8'hFF;
            next_pins.port_d_data = 1'b1;
         end
         oma_pkg::OMA_CLS_EXP_ROM: begin
            next_pins.port_a_addr = pin_function_ctrl_one;
            next_pins.port_b_addr = pin_function_ctrl_one;
            next_pins.port_c_addr = portc_dir;
            next_pins.port_d_data = 1'b1;
         end
         default: next_pins = '0;
      endcase
      next_pins.port_e_data = expanded && (area_width != `OMA_AREA_ALL_NARROW);
      // in expanded modes pf5 and pf4 always control; pf3 unless disabled; pf7 clock out
      next_pins.port_f_ctrl = expanded ?
         {1'b1, 1'b0, 2'b11, !system_control_reg[`OMA_BIT_LWR_OFF], 3'b000} :
         8'h00;
   end

   // pin use, registered so every pin function comes straight from a flop
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_pins <= '0;
      end else begin
         o_pins <= next_pins;
      end
   end

   // bus width: in expanded modes wide as soon as any area is wide, narrow when all are narrow; single-chip is always narrow
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_bus_16bit <= 1'b0;
      end else begin
         o_bus_16bit <= expanded && (area_width != `OMA_AREA_ALL_NARROW);
      end
   end

   // on-chip rom is on in the rom-enabled expanded and single-chip modes; off in the two rom-less expanded ones and for unsupported straps
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_rom_enable <= 1'b0;
      end else begin
         o_rom_enable <= (mode_class == oma_pkg::OMA_CLS_EXP_ROM) ||
                         (mode_class == oma_pkg::OMA_CLS_SINGLE);
      end
   end

   // flash writing only in the boot and user program modes
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_flash_prog_allowed <= 1'b0;
      end else begin
         o_flash_prog_allowed <= flash_mode;
      end
   end

   // unsupported strap, shown only once the mode has been latched
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_mode_bad <= 1'b0;
      end else begin
         o_mode_bad <= captured && (mode_class == oma_pkg::OMA_CLS_BAD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decoder

   // decoder working signals and one hit flag per region of the map
   oma_pkg::oma_decode_type next_decode;
   logic [`OMA_ADDR_W-1:0] a;
   logic in_rom_low;
   logic in_rom_high;
   logic in_rsv_low;
   logic in_rsv_high;
   logic in_ram;
   logic in_io_low;
   logic in_io_high;
   logic in_flash;

   assign a = i_cpu_addr;

   // region compares, kept apart from the mode logic so each boundary is written once
   assign in_rom_low = (a < `OMA_A_ROM_LOW_END);
   assign in_rom_high = (a >= `OMA_A_ROM_LOW_END) && (a < `OMA_A_ROM_END);
   assign in_rsv_low = (a >= `OMA_A_ROM_END) && (a < `OMA_A_RSV1_END);
   assign in_rsv_high = (a >= `OMA_A_RSV2_LO) && (a < `OMA_A_RAM_LO);
   assign in_ram = (a >= `OMA_A_RAM_LO) && (a < `OMA_A_RAM_END);
   assign in_io_low = (a >= `OMA_A_IO1_LO) && (a < `OMA_A_IO1_END);
   assign in_io_high = (a >= `OMA_A_IO2_LO);
   assign in_flash = (a >= `OMA_A_FLASH_LO) && (a <= `OMA_A_FLASH_HI);

   // region decode with the control bits applied
   always_comb begin
      next_decode.area = a[`OMA_AREA_MSB:`OMA_AREA_LSB];
      next_decode.wide = area_width[a[`OMA_AREA_MSB:`OMA_AREA_LSB]];
      next_decode.target = expanded ? oma_pkg::OMA_TGT_EXTERNAL :
                                      oma_pkg::OMA_TGT_RESERVED;
      if (in_rom_low) begin
         if (mode_class != oma_pkg::OMA_CLS_EXP_NOROM) begin
            next_decode.target = oma_pkg::OMA_TGT_ROM;
         end
      end else if (in_rom_high) begin
         if (mode_class == oma_pkg::OMA_CLS_EXP_ROM) begin
            next_decode.target = external_area_enable ?
               oma_pkg::OMA_TGT_EXTERNAL : oma_pkg::OMA_TGT_ROM;
         end else if (mode_class == oma_pkg::OMA_CLS_SINGLE) begin
            next_decode.target = external_area_enable ?
               oma_pkg::OMA_TGT_RESERVED : oma_pkg::OMA_TGT_ROM;
         end
      end else if (in_rsv_low) begin
         next_decode.target = oma_pkg::OMA_TGT_RESERVED;
      end else if (in_rsv_high) begin
         next_decode.target = oma_pkg::OMA_TGT_RESERVED;
      end else if (in_ram) begin
         if (internal_ram_enable || !expanded) begin
            next_decode.target = oma_pkg::OMA_TGT_RAM;
         end else begin
            next_decode.target = oma_pkg::OMA_TGT_EXTERNAL;
         end
      end else if (in_io_low) begin
         next_decode.target = oma_pkg::OMA_TGT_IOREG;
      end else if (in_io_high) begin
         next_decode.target = oma_pkg::OMA_TGT_IOREG;
         if (flash_reg_window_enable && in_flash) begin
            next_decode.target = oma_pkg::OMA_TGT_FLASH_REG;
         end
      end
      if (mode_class == oma_pkg::OMA_CLS_BAD) begin
         next_decode.target = oma_pkg::OMA_TGT_RESERVED;
      end
   end

   // decode answer one cycle after the address
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_decode <= '{target: oma_pkg::OMA_TGT_RESERVED, area: `OMA_RST_AREA, wide: 1'b0};
      end else begin
         o_decode <= next_decode;
      end
   end

endmodule : oma_mode_map

// *** core/oma_pkg.sv ***
// types for the operating-mode and address-map block
package oma_pkg;
   // class of operation derived from the mode inputs
   typedef enum logic [1:0] {
      OMA_CLS_EXP_NOROM = 2'b00,
      OMA_CLS_EXP_ROM = 2'b01,
      OMA_CLS_SINGLE = 2'b10,
      OMA_CLS_BAD = 2'b11
   } oma_class_type;

   // decoded target of an address
   typedef enum logic [2:0] {
      OMA_TGT_ROM = 3'b000,
      OMA_TGT_RAM = 3'b001,
      OMA_TGT_IOREG = 3'b010,
      OMA_TGT_EXTERNAL = 3'b011,
      OMA_TGT_RESERVED = 3'b100,
      OMA_TGT_FLASH_REG = 3'b101
   } oma_target_type;

   // port function summary for ports a to f
   typedef struct packed {
      logic [7:0] port_a_addr;
      logic [7:0] port_b_addr;
      logic [7:0] port_c_addr;
      logic port_d_data;
      logic port_e_data;
      logic [7:0] port_f_ctrl;
   } oma_pins_type;

   // answer of the address decoder
   typedef struct packed {
      oma_target_type target;
      logic [2:0] area;
      logic wide;
   } oma_decode_type;
endpackage : oma_pkg

// *** verif/oma_board_strap.sv ***
// board strap model that drives the mode inputs
`timescale 1ns/10ps

module oma_board_strap (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [3:0] i_strap,
   output logic [2:0] o_mode_select_inputs,
   output logic o_flash_write_enable_pin
);
   // straps follow the jumpers only in reset, then hold until the next reset
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         {o_flash_write_enable_pin, o_mode_select_inputs} <= i_strap;
      end
   end
endmodule : oma_board_strap

// *** verif/oma_mode_map_sva.sv ***
// checker for the operating-mode and address-map block
`timescale 1ns/10ps
`include "oma_consts.svh"

module oma_mode_map_sva (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_reg_rd,
   input wire logic [`OMA_REG_ADDR_W-1:0] i_reg_addr,
   input wire logic [`OMA_ADDR_W-1:0] i_cpu_addr,
   input wire logic [7:0] o_reg_rdata,
   input oma_pkg::oma_decode_type o_decode,
   input oma_pkg::oma_pins_type o_pins,
   input wire logic o_bus_16bit,
   input wire logic o_rom_enable,
   input wire logic o_flash_prog_allowed,
   input wire logic o_mode_bad
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic [1:0] up;

   // edges since reset release, so mode outputs are only judged once settled
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read of the flash select register
   sequence s_rd_flash;
      i_reg_rd && (i_reg_addr == `OMA_OFF_FLASH_SEL);
   endsequence

   a_flash_low_zero: assert property (s_rd_flash |=> o_reg_rdata[2:0] == 3'h0)
      else $error("flash select low bits not zero");
   a_window_only: assert property (o_decode.target == oma_pkg::OMA_TGT_FLASH_REG
      |-> $past(i_cpu_addr) inside {[`OMA_A_FLASH_LO:`OMA_A_FLASH_HI]})
      else $error("flash target outside its window");
   a_area_bits: assert property ($past(i_rst_n)
      |-> o_decode.area == $past(i_cpu_addr[23:21]))
      else $error("area field differs from top address bits");
   a_io_window: assert property (up == 2'h3 && !o_mode_bad
      && ($past(i_cpu_addr) inside {[24'hFFFE50:24'hFFFF07]})
      |-> o_decode.target == oma_pkg::OMA_TGT_IOREG)
      else $error("register window not decoded internal");
   a_no_rom_off: assert property (up == 2'h3 && !o_rom_enable
      |-> o_decode.target != oma_pkg::OMA_TGT_ROM)
      else $error("rom decoded while rom disabled");
   a_single_pins: assert property (up == 2'h3 && !o_pins.port_d_data |-> o_pins == '0)
      else $error("pins claimed without data bus");
   a_exp_ctrl: assert property (up == 2'h3 && o_pins.port_d_data
      |-> o_pins.port_f_ctrl[5:4] == 2'b11)
      else $error("middle port f pins not bus control");
   a_upper_data: assert property (up == 2'h3 && o_pins.port_d_data
      |-> o_pins.port_e_data == o_bus_16bit)
      else $error("port e data use differs from bus width");
   a_flash_rom: assert property (up == 2'h3 && o_flash_prog_allowed |-> o_rom_enable)
      else $error("flash writing without rom enabled");
endmodule : oma_mode_map_sva

bind oma_mode_map oma_mode_map_sva u_sva (.i_clk_sys, .i_rst_n, .i_reg_rd, .i_reg_addr,
   .i_cpu_addr, .o_reg_rdata, .o_decode, .o_pins, .o_bus_16bit, .o_rom_enable,
   .o_flash_prog_allowed, .o_mode_bad);

// *** verif/testbench.sv ***
// self-checking bench for the operating-mode and address-map block
`timescale 1ns/10ps

module testbench;
   logic i_clk_sys;
   logic i_rst_n;
   logic [3:0] strap;
   wire logic [2:0] i_mode_select_inputs;
   wire logic i_flash_write_enable_pin;
   logic [3:0] i_reg_addr;
   logic [7:0] i_reg_wdata;
   logic i_reg_wr;
   logic i_reg_rd;
   logic [23:0] i_cpu_addr;
   logic [7:0] o_reg_rdata;
   oma_pkg::oma_decode_type o_decode;
   oma_pkg::oma_pins_type o_pins;
   logic o_bus_16bit;
   logic o_rom_enable;
   logic o_flash_prog_allowed;
   logic o_mode_bad;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [11:0] r;
   // mode, {rom, flash, bus16, data bus, bad}, target at address zero
   logic [11:0] rows [8] = '{12'h433, 12'h513, 12'h690, 12'h780,
      12'hAD0, 12'hBC0, 12'hED0, 12'hFC0};
   // address and expected target in mode 4
   logic [26:0] map_tab [8] = '{{24'h060000, 3'h4}, {24'hFF7400, 3'h4},
      {24'hFF7C00, 3'h1}, {24'hFFFE4F, 3'h3}, {24'hFFFF07, 3'h2},
      {24'hFFFF08, 3'h3}, {24'hFFFF27, 3'h3}, {24'hFFFF28, 3'h2}};

   oma_board_strap u_strap (.i_clk_sys, .i_rst_n, .i_strap(strap),
      .o_mode_select_inputs(i_mode_select_inputs),
      .o_flash_write_enable_pin(i_flash_write_enable_pin));
   oma_mode_map uut (.i_clk_sys, .i_rst_n, .i_mode_select_inputs,
      .i_flash_write_enable_pin, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .i_cpu_addr, .o_reg_rdata, .o_decode, .o_pins, .o_bus_16bit, .o_rom_enable,
      .o_flash_prog_allowed, .o_mode_bad);

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      #1 chk(o_reg_rdata, e);
   endtask : rd

   task automatic dec(input logic [23:0] a, input logic [2:0] e);
      @(posedge i_clk_sys);
      i_cpu_addr <= a;
      @(posedge i_clk_sys);
      #1 chk(o_decode.target, e);
   endtask : dec

   task automatic boot(input logic [3:0] m);
      @(posedge i_clk_sys);
      strap <= m;
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask : boot

   task automatic settle;
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask : settle

   task automatic close_out;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         close_out();
      end
   end

   // main sequence: table of modes, then hand-written cases
   initial begin
      i_rst_n = 1'b0;
      strap = 4'h4;
      i_reg_addr = 4'h0;
      i_reg_wdata = 8'h00;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_cpu_addr = 24'h000000;
      foreach (rows[k]) begin
         r = rows[k];
         boot(r[11:8]);
         chk({o_rom_enable, o_flash_prog_allowed, o_bus_16bit, o_pins.port_d_data,
            o_mode_bad}, r[7:3]);
         chk(o_pins.port_b_addr, (r[11:8] < 4'h6) ? 8'hFF : 8'h00);
         rd(4'h0, 8'h00);
         rd(4'h1, 8'h01);
         rd(4'h2, 8'h00);
         rd(4'h3, (r[11:8] == 4'h4) ? 8'hFF : 8'h00);
         rd(4'h4, {4'h0, r[11:8]});
         rd(4'hF, 8'h00);
         dec(24'h000000, r[2:0]);
         dec(24'hFFFF00, 3'h2);
      end
      // mode 4: flash window, refused writes, map edges, ram and width
      boot(4'h4);
      dec(24'hFFFFC8, 3'h2);
      wr(4'h0, 8'hF8);
      wr(4'h4, 8'hFF);
      rd(4'h0, 8'h08);
      rd(4'h4, 8'h04);
      dec(24'hFFFFC8, 3'h5);
      dec(24'hFFFFCB, 3'h5);
      dec(24'hFFFFCC, 3'h2);
      foreach (map_tab[k]) dec(map_tab[k][26:3], map_tab[k][2:0]);
      chk(o_pins.port_f_ctrl[5:3], 3'h7);
      wr(4'h1, 8'h04);
      dec(24'hFF7C00, 3'h3);
      chk(o_pins.port_f_ctrl[5:3], 3'h6);
      dec(24'hE00000, 3'h3);
      chk({o_decode.area, o_decode.wide}, 4'hF);
      wr(4'h3, 8'h7F);
      dec(24'hE00000, 3'h3);
      chk({o_decode.area, o_decode.wide, o_bus_16bit}, 5'h1D);
      wr(4'h3, 8'h00);
      settle();
      chk(o_bus_16bit, 1'b0);
      // mode 5: one wide area widens the bus
      boot(4'h5);
      wr(4'h3, 8'h01);
      settle();
      chk({o_bus_16bit, o_pins.port_e_data}, 2'h3);
      // mode 6: address pins by function bits, region by area enable
      boot(4'h6);
      chk(o_pins.port_c_addr, 8'h00);
      wr(4'h5, 8'hFF);
      wr(4'h6, 8'hFF);
      settle();
      chk(o_pins.port_c_addr, 8'hFF);
      chk((o_pins.port_a_addr | o_pins.port_b_addr) != 8'h00, 1'b1);
      wr(4'h2, 8'h20);
      dec(24'h010000, 3'h3);
      // mode 15: single-chip region turns reserved
      boot(4'hF);
      wr(4'h2, 8'h20);
      dec(24'h010000, 3'h4);
      dec(24'h00FFFF, 3'h0);
      // unsupported strap gives no usable map
      boot(4'h8);
      chk(o_mode_bad, 1'b1);
      dec(24'h000000, 3'h4);
      close_out();
   end
endmodule : testbench
